// ### pkg/ahi_pkg.sv
// Shared constants for the converter host interface and its controller.
// What this block does
// - Interface-select pin low parallel, high serial.
// - Parallel width-select low 16-bit, high 8-bit.
// - Byte-order pin picks first byte on upper lines.
// - Serial transfer starts at frame sync fall.
// - MSB first, change on rise, sample on fall.
// - Short results padded to 16 bits with zeros.
// - Config input captured on serial clock fall.
// - Three outputs carry own pair, first channel first.
// - Two outputs: A0 A1 C0 and B0 B1 C1.
// - One output: A0 A1 B0 B1 C0 C1.
// - Hardware mode: pins plus few register override bits.
// - Hardware serial mode ignores upper config byte.
// - Software mode: register only, pair A starts all unless bit 23 set.
// - Host keeps select low over full parallel update.
// - Single upper-line write updates upper byte only.
// - Word mode holds middle byte until second write.
// - Host sends config with every serial software access.
// - Host initialises with all 32 bits, update bit set.
// - Register writable only in software mode, kept otherwise.
// - Apply at strobe rise or 32nd serial fall.
// - Register resets to 0x000003ff.
// - Serial: update-enable bit clear updates upper byte only.
// - Readback bit shifts register out instead of results.
package ahi_pkg;
   localparam int          CFG_W           = 32;
   localparam logic [31:0] CFG_RESET       = 32'h0000_03ff;
   localparam logic [31:0] HW_OVERRIDE_MASK = 32'h007c_e3ff;
   localparam int          UPPER_LSB       = 24;
   localparam int          MID_LSB         = 16;
   localparam int          FULL_UPDATE_BIT = 16;
   localparam int          READBACK_BIT    = 17;
   localparam int          SEQ_BIT         = 23;
   localparam int          RESULT_W        = 16;
   localparam int          CHANNELS        = 6;
   localparam int          LANE_W          = RESULT_W * CHANNELS;
   localparam int          SER_APPLY_EDGE  = 32;
   localparam int          CLK_PERIOD_NS   = 100;
   localparam int          LINK_HALF_NS    = 400;
   localparam int          LINK_HALF_CYCLES = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Controller register offsets.
   localparam logic [4:0]  OFS_CTRL   = 5'h00;
   localparam logic [4:0]  OFS_CMD    = 5'h04;
   localparam logic [4:0]  OFS_TXDATA = 5'h08;
   localparam logic [4:0]  OFS_STATUS = 5'h0c;
   localparam logic [4:0]  OFS_RXA    = 5'h10;
   localparam logic [4:0]  OFS_RXB    = 5'h14;
   localparam logic [4:0]  OFS_RXC    = 5'h18;
   localparam logic [4:0]  OFS_PRDATA = 5'h1c;
   // Control register fields.
   localparam int          CTRL_IFSEL   = 0;
   localparam int          CTRL_BYTEW   = 1;
   localparam int          CTRL_BORDER  = 2;
   localparam int          CTRL_CFGSRC  = 3;
   localparam int          CTRL_SSEL    = 4;
   localparam int          CTRL_START   = 7;
   localparam int          CTRL_CSHOLD  = 10;
   localparam int          CTRL_W       = 11;
   localparam int          CMD_BITS_LSB = 8;
   typedef enum logic [1:0] {AHI_OP_NONE, AHI_OP_SERIAL, AHI_OP_PWRITE, AHI_OP_PREAD} ahi_op_t;
endpackage

// ### pkg/ahi_link_if.sv
// Pins between the converter interface and its host controller.
`timescale 1ns/10ps
interface ahi_link_if;
   logic        interfaceSelect;
   logic        wordByteSelect;
   logic        byteOrderSelect;
   logic        configSourceSelect;
   logic [2:0]  serialSelect;
   logic [2:0]  pairStart;
   logic        chipSelectN;
   logic        writeStrobeN;
   logic        readStrobeN;
   logic        frameSyncIn;
   logic        serialClock;
   logic        serialConfigIn;
   logic        serialOutA;
   logic        serialOutB;
   logic        serialOutC;
   logic [15:0] hostDataOut;
   logic        hostDataOe;
   logic [15:0] devDataOut;
   logic        devDataOe;
   logic [15:0] parallelDataBus;

   // Resolved level of the shared parallel bus.
   assign parallelDataBus = devDataOe ? devDataOut : (hostDataOe ? hostDataOut : 16'h0000);

   modport device (
      input  interfaceSelect, wordByteSelect, byteOrderSelect, configSourceSelect,
      input  serialSelect, pairStart, chipSelectN, writeStrobeN, readStrobeN,
      input  frameSyncIn, serialClock, serialConfigIn, parallelDataBus,
      output serialOutA, serialOutB, serialOutC, devDataOut, devDataOe
   );
   modport host (
      output interfaceSelect, wordByteSelect, byteOrderSelect, configSourceSelect,
      output serialSelect, pairStart, chipSelectN, writeStrobeN, readStrobeN,
      output frameSyncIn, serialClock, serialConfigIn, hostDataOut, hostDataOe,
      input  serialOutA, serialOutB, serialOutC, parallelDataBus
   );
endinterface

// ### logic/ahi_sync3.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/10ps
module ahi_sync3 #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
)(
   input  wire logic         ref_clk,
   input  wire logic         reset,
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] stableOut
);
   logic [W-1:0] stage1_reg;
   logic [W-1:0] stage2_reg;
   logic [W-1:0] stage3_reg;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         stage1_reg <= INIT;
         stage2_reg <= INIT;
         stage3_reg <= INIT;
         stableOut  <= INIT;
      end
      else
      begin
         stage1_reg <= asyncIn;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         stableOut  <= (stage2_reg & ~(stage2_reg ^ stage3_reg))
                     | (stableOut & (stage2_reg ^ stage3_reg));
      end
   end
endmodule // ahi_sync3

// ### logic/ahi_device_end.sv
// Converter-side host interface: parallel and serial ports and configuration register.
`timescale 1ns/10ps
module ahi_device_end
   import ahi_pkg::*;
#(
   parameter int RESOLUTION = 16
)(
   input  wire logic                ref_clk,
   input  wire logic                reset,
   ahi_link_if.device               link,
   input  wire logic [LANE_W-1:0]   convResult,
   output logic      [CFG_W-1:0]    converterConfig,
   output logic      [CFG_W-1:0]    appliedConfig,
   output logic      [2:0]          convStart
);
   // ==========================================================
   // Input synchronisation
   localparam int SW = 32;
   logic [SW-1:0] syncIn;
   logic [SW-1:0] syncOut;
   logic [SW-1:0] prev_reg;

   assign syncIn = {link.parallelDataBus, link.pairStart, link.serialSelect,
                    link.configSourceSelect, link.byteOrderSelect, link.wordByteSelect,
                    link.interfaceSelect, link.serialConfigIn, link.serialClock,
                    link.frameSyncIn, link.readStrobeN, link.writeStrobeN, link.chipSelectN};

   ahi_sync3 #(.W(SW), .INIT(32'h0000_003f)) inSync (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .asyncIn   (syncIn),
      .stableOut (syncOut)
   );

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         prev_reg <= 32'h0000_003f;
      else
         prev_reg <= syncOut;
   end

   logic        csN, wrN, rdN, fs, sclk, serial_config_in, ifSerial, byteMode, byteOrder, swMode;
   logic [2:0]  sSel, pStart;
   logic [15:0] busIn;
   logic        wrRise, rdRise, csRise, fsFall, sclkRise, sclkFall;

   assign {busIn, pStart, sSel, swMode, byteOrder, byteMode, ifSerial,
           serial_config_in, sclk, fs, rdN, wrN, csN} = syncOut;
   assign wrRise   = wrN & ~prev_reg[1];
   assign rdRise   = rdN & ~prev_reg[2];
   assign fsFall   = ~fs & prev_reg[3];
   assign sclkRise = sclk & ~prev_reg[4];
   assign sclkFall = ~sclk & prev_reg[4];
   assign csRise   = csN & ~prev_reg[0];

   // ==========================================================
   // Result padding and lane ordering
   function automatic logic [RESULT_W-1:0] padResult(input logic [RESULT_W-1:0] r);
      padResult = r & ~({RESULT_W{1'b1}} << RESOLUTION);
   endfunction

   logic [RESULT_W-1:0] ch [CHANNELS];
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++)
      begin : gPad
         assign ch[g] = padResult(convResult[LANE_W-1-g*RESULT_W -: RESULT_W]);
      end
   endgenerate

   logic [LANE_W-1:0] laneA, laneB, laneC;
   always_comb
   begin
      laneA = '0;
      laneB = '0;
      laneC = '0;
      if (converterConfig[READBACK_BIT])
      begin
         laneA = {converterConfig, {(LANE_W-CFG_W){1'b0}}};
         laneB = {converterConfig, {(LANE_W-CFG_W){1'b0}}};
         laneC = {converterConfig, {(LANE_W-CFG_W){1'b0}}};
      end
      else if (sSel == 3'h7)
      begin
         laneA = {ch[0], ch[1], {(LANE_W-2*RESULT_W){1'b0}}};
         laneB = {ch[2], ch[3], {(LANE_W-2*RESULT_W){1'b0}}};
         laneC = {ch[4], ch[5], {(LANE_W-2*RESULT_W){1'b0}}};
      end
      else if (sSel == 3'h3)
      begin
         laneA = {ch[0], ch[1], ch[4], {(LANE_W-3*RESULT_W){1'b0}}};
         laneB = {ch[2], ch[3], ch[5], {(LANE_W-3*RESULT_W){1'b0}}};
      end
      else
         laneA = {ch[0], ch[1], ch[2], ch[3], ch[4], ch[5]};
   end

   // ==========================================================
   // Serial output shifting
   logic [LANE_W-1:0] shA_reg, shB_reg, shC_reg;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         shA_reg <= '0;
         shB_reg <= '0;
         shC_reg <= '0;
      end
      else if (ifSerial && fsFall)
      begin
         shA_reg <= laneA;
         shB_reg <= laneB;
         shC_reg <= laneC;
      end
      else if (ifSerial && !fs && sclkRise)
      begin
         shA_reg <= {shA_reg[LANE_W-2:0], 1'b0};
         shB_reg <= {shB_reg[LANE_W-2:0], 1'b0};
         shC_reg <= {shC_reg[LANE_W-2:0], 1'b0};
      end
   end

   assign link.serialOutA = shA_reg[LANE_W-1];
   assign link.serialOutB = shB_reg[LANE_W-1];
   assign link.serialOutC = shC_reg[LANE_W-1];

   // ==========================================================
   // Serial configuration input
   logic [CFG_W-1:0] sdiShift_reg;
   logic [6:0]       fallCount_reg;
   logic             serApply;
   logic [CFG_W-1:0] sdiWord;

   assign sdiWord  = {sdiShift_reg[CFG_W-2:0], serial_config_in};
   assign serApply = ifSerial && !fs && sclkFall && swMode
                     && fallCount_reg == 7'(SER_APPLY_EDGE - 1);

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         sdiShift_reg  <= '0;
         fallCount_reg <= '0;
      end
      else if (fsFall)
         fallCount_reg <= '0;
      else if (ifSerial && !fs && sclkFall)
      begin
         sdiShift_reg <= sdiWord;
         if (fallCount_reg != 7'h7f)
            fallCount_reg <= fallCount_reg + 7'h01;
      end
   end

   // ==========================================================
   // Parallel write sequencing
   logic [1:0]  wrPhase_reg;
   logic [23:0] pending_reg;
   logic        parWrite;

   assign parWrite = !ifSerial && wrRise && !csN && swMode;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         wrPhase_reg <= '0;
         pending_reg <= '0;
      end
      else if (csRise)
         wrPhase_reg <= '0;
      else if (parWrite)
      begin
         if (!byteMode)
         begin
            if (wrPhase_reg == 2'h0)
               pending_reg[23:16] <= busIn[7:0];
            wrPhase_reg <= (wrPhase_reg == 2'h0) ? 2'h1 : 2'h0;
         end
         else
         begin
            if (wrPhase_reg == 2'h1)
               pending_reg[23:16] <= busIn[15:8];
            if (wrPhase_reg == 2'h2)
               pending_reg[15:8] <= busIn[15:8];
            wrPhase_reg <= wrPhase_reg + 2'h1;
         end
      end
   end

   // ==========================================================
   // Configuration register
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         converterConfig <= CFG_RESET;
      else if (serApply)
      begin
         converterConfig[CFG_W-1:UPPER_LSB] <= sdiWord[CFG_W-1:UPPER_LSB];
         if (sdiWord[FULL_UPDATE_BIT])
            converterConfig[UPPER_LSB-1:0] <= sdiWord[UPPER_LSB-1:0];
      end
      else if (parWrite)
      begin
         if (wrPhase_reg == 2'h0)
            converterConfig[CFG_W-1:UPPER_LSB] <= busIn[15:8];
         else if (!byteMode)
            converterConfig[UPPER_LSB-1:0] <= {pending_reg[23:16], busIn};
         else if (wrPhase_reg == 2'h3)
            converterConfig[UPPER_LSB-1:0] <= {pending_reg[23:8], busIn[15:8]};
      end
   end

   // ==========================================================
   // Parallel read port
   logic [3:0]  rdIdx_reg;
   logic [15:0] dataOut_reg;
   logic        dataOe_reg;
   logic [15:0] rdWord;
   logic [2:0]  wordSel;
   logic        highFirst;

   assign wordSel   = byteMode ? 3'(rdIdx_reg >> 1) : rdIdx_reg[2:0];
   assign rdWord    = (wordSel < 3'(CHANNELS)) ? ch[wordSel] : 16'h0000;
   assign highFirst = rdIdx_reg[0] ^ byteOrder;

   always_ff @(posedge ref_clk)
   begin
      if (reset || csRise)
         rdIdx_reg <= '0;
      else if (!ifSerial && !csN && rdRise)
         rdIdx_reg <= (rdIdx_reg == (byteMode ? 4'hb : 4'h5)) ? 4'h0 : rdIdx_reg + 4'h1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         dataOut_reg <= '0;
         dataOe_reg  <= 1'b0;
      end
      else
      begin
         dataOe_reg <= !ifSerial && !csN && !rdN;
         if (!byteMode)
            dataOut_reg <= rdWord;
         else
            dataOut_reg <= {highFirst ? rdWord[15:8] : rdWord[7:0], 8'h00};
      end
   end

   assign link.devDataOut = dataOut_reg;
   assign link.devDataOe  = dataOe_reg;

   // ==========================================================
   // Effective configuration and conversion start
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         appliedConfig <= CFG_RESET & HW_OVERRIDE_MASK;
         convStart     <= '0;
      end
      else
      begin
         appliedConfig <= swMode ? converterConfig
                                 : (converterConfig & HW_OVERRIDE_MASK);
         convStart     <= (swMode && !converterConfig[SEQ_BIT]) ? {3{pStart[0]}} : pStart;
      end
   end
endmodule // ahi_device_end

// ### logic/ahi_host_end.sv
// Host controller driving the converter link, ordered over Wishbone.
`timescale 1ns/10ps
module ahi_host_end
   import ahi_pkg::*;
#(
   parameter int HALF_CYCLES = LINK_HALF_CYCLES
)(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   ahi_link_if.host         link
);
   typedef enum {S_IDLE, S_SER_FALL, S_SER_RISE, S_SER_END,
                 S_PW_LOW, S_PW_HOLD, S_PR_LOW, S_PR_SAMPLE} ahi_state_t;

   // ==========================================================
   // Register bus
   logic [CTRL_W-1:0] ctrl_reg;
   logic [31:0]       tx_reg;
   logic [31:0]       rxA_reg, rxB_reg, rxC_reg;
   logic [15:0]       prData_reg;
   logic              cmdGo;
   ahi_op_t           cmdOp;
   logic [6:0]        cmdBits;
   ahi_state_t        state_reg;
   logic              busy;
   logic              wbReq;

   assign busy  = state_reg != S_IDLE;
   assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign cmdGo = wbReq && wb_we_i && wb_adr_i == OFS_CMD && wb_sel_i[0] && !busy;
   assign cmdOp = ahi_op_t'(wb_dat_i[1:0]);
   assign cmdBits = wb_dat_i[CMD_BITS_LSB +: 7];

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wbReq;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         ctrl_reg <= '0;
         tx_reg   <= '0;
      end
      else if (wbReq && wb_we_i)
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (wb_sel_i[i] && wb_adr_i == OFS_TXDATA)
               tx_reg[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
         end
         if (wb_adr_i == OFS_CTRL && wb_sel_i[0])
            ctrl_reg[7:0] <= wb_dat_i[7:0];
         if (wb_adr_i == OFS_CTRL && wb_sel_i[1])
            ctrl_reg[CTRL_W-1:8] <= wb_dat_i[CTRL_W-1:8];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         wb_dat_o <= '0;
      else if (wbReq && !wb_we_i)
      begin
         case (wb_adr_i)
            OFS_CTRL:   wb_dat_o <= 32'(ctrl_reg);
            OFS_TXDATA: wb_dat_o <= tx_reg;
            OFS_STATUS: wb_dat_o <= {31'h0, busy};
            OFS_RXA:    wb_dat_o <= rxA_reg;
            OFS_RXB:    wb_dat_o <= rxB_reg;
            OFS_RXC:    wb_dat_o <= rxC_reg;
            OFS_PRDATA: wb_dat_o <= {16'h0, prData_reg};
            default:    wb_dat_o <= 32'h0;
         endcase
      end
   end

   // ==========================================================
   // Link clock divider
   logic [7:0] div_reg;
   logic       tick;

   assign tick = div_reg == 8'(HALF_CYCLES - 1);

   always_ff @(posedge ref_clk)
   begin
      if (reset || cmdGo || tick)
         div_reg <= '0;
      else
         div_reg <= div_reg + 8'h01;
   end

   // ==========================================================
   // Link sequencer
   logic [31:0] txShift_reg;
   logic [6:0]  bitCnt_reg;
   logic        fs_reg, sclk_reg, sdi_reg, wrN_reg, rdN_reg, csN_reg, oe_reg;
   logic [15:0] hostData_reg;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_reg    <= S_IDLE;
         txShift_reg  <= '0;
         bitCnt_reg   <= '0;
         fs_reg       <= 1'b1;
         sclk_reg     <= 1'b1;
         sdi_reg      <= 1'b0;
         wrN_reg      <= 1'b1;
         rdN_reg      <= 1'b1;
         oe_reg       <= 1'b0;
         hostData_reg <= '0;
         rxA_reg      <= '0;
         rxB_reg      <= '0;
         rxC_reg      <= '0;
         prData_reg   <= '0;
      end
      else
      begin
         case (state_reg)
            S_IDLE:
               if (cmdGo)
               begin
                  case (cmdOp)
                     AHI_OP_SERIAL:
                     begin
                        fs_reg      <= 1'b0;
                        sdi_reg     <= tx_reg[31];
                        txShift_reg <= {tx_reg[30:0], 1'b0};
                        bitCnt_reg  <= cmdBits;
                        state_reg   <= (cmdBits == 7'h0) ? S_SER_END : S_SER_FALL;
                     end
                     AHI_OP_PWRITE:
                     begin
                        hostData_reg <= tx_reg[15:0];
                        oe_reg       <= 1'b1;
                        wrN_reg      <= 1'b0;
                        state_reg    <= S_PW_LOW;
                     end
                     AHI_OP_PREAD:
                     begin
                        rdN_reg   <= 1'b0;
                        state_reg <= S_PR_LOW;
                     end
                     default:
                        state_reg <= S_IDLE;
                  endcase
               end
            S_SER_FALL:
               if (tick)
               begin
                  sclk_reg   <= 1'b0;
                  bitCnt_reg <= bitCnt_reg - 7'h01;
                  state_reg  <= S_SER_RISE;
               end
            S_SER_RISE:
               if (tick)
               begin
                  // Each bit is taken at the end of the low phase, as the device shifts late.
                  rxA_reg     <= {rxA_reg[30:0], link.serialOutA};
                  rxB_reg     <= {rxB_reg[30:0], link.serialOutB};
                  rxC_reg     <= {rxC_reg[30:0], link.serialOutC};
                  sclk_reg    <= 1'b1;
                  sdi_reg     <= txShift_reg[31];
                  txShift_reg <= {txShift_reg[30:0], 1'b0};
                  state_reg   <= (bitCnt_reg == 7'h0) ? S_SER_END : S_SER_FALL;
               end
            S_SER_END:
               if (tick)
               begin
                  fs_reg    <= 1'b1;
                  state_reg <= S_IDLE;
               end
            S_PW_LOW:
               if (tick)
               begin
                  wrN_reg   <= 1'b1;
                  state_reg <= S_PW_HOLD;
               end
            S_PW_HOLD:
               if (tick)
               begin
                  oe_reg    <= 1'b0;
                  state_reg <= S_IDLE;
               end
            S_PR_LOW:
               if (tick)
                  state_reg <= S_PR_SAMPLE;
            S_PR_SAMPLE:
               if (tick)
               begin
                  prData_reg <= link.parallelDataBus;
                  rdN_reg    <= 1'b1;
                  state_reg  <= S_IDLE;
               end
            default:
               state_reg <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         csN_reg <= 1'b1;
      else
         csN_reg <= !(ctrl_reg[CTRL_CSHOLD] || busy || cmdGo);
   end

   assign link.interfaceSelect    = ctrl_reg[CTRL_IFSEL];
   assign link.wordByteSelect     = ctrl_reg[CTRL_BYTEW];
   assign link.byteOrderSelect    = ctrl_reg[CTRL_BORDER];
   assign link.configSourceSelect = ctrl_reg[CTRL_CFGSRC];
   assign link.serialSelect       = ctrl_reg[CTRL_SSEL +: 3];
   assign link.pairStart          = ctrl_reg[CTRL_START +: 3];
   assign link.chipSelectN        = csN_reg;
   assign link.writeStrobeN       = wrN_reg;
   assign link.readStrobeN        = rdN_reg;
   assign link.frameSyncIn        = fs_reg;
   assign link.serialClock        = sclk_reg;
   assign link.serialConfigIn     = sdi_reg;
   assign link.hostDataOut        = hostData_reg;
   assign link.hostDataOe         = oe_reg;
endmodule // ahi_host_end

// ### testbench/ahi_link_chk.sv
// Checker on the link between the host end and the device end.
`timescale 1ns/10ps
// ==========
// Link checker.
module ahi_link_chk (
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire logic        interfaceSelect,
   input wire logic        chipSelectN,
   input wire logic        writeStrobeN,
   input wire logic        readStrobeN,
   input wire logic        frameSyncIn,
   input wire logic        serialClock,
   input wire logic [15:0] hostDataOut,
   input wire logic        hostDataOe,
   input wire logic        devDataOe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   idle_clock_a: assert property (frameSyncIn |-> serialClock)
      else $error("serial clock moved outside a frame");
   low_phase_a: assert property ($fell(serialClock) |-> !serialClock[*4])
      else $error("serial clock low phase too short");
   bus_owner_a: assert property (!(devDataOe && hostDataOe))
      else $error("both ends drive the parallel bus");
   serial_quiet_a: assert property (interfaceSelect |-> !devDataOe)
      else $error("parallel bus driven in serial mode");
   strobe_select_a: assert property (!writeStrobeN |-> !chipSelectN)
      else $error("write strobe without chip select");
   write_hold_a: assert property ($fell(writeStrobeN) |=>
      (hostDataOe && $stable(hostDataOut))[*4])
      else $error("write data not held under strobe");
   read_answer_a: assert property ($fell(readStrobeN) && !chipSelectN && !interfaceSelect
      |-> ##[2:7] devDataOe)
      else $error("read strobe not answered");
   read_release_a: assert property ($rose(readStrobeN) |-> ##[1:8] !devDataOe)
      else $error("bus not released after read");
   cover property ($fell(frameSyncIn));
   cover property ($rose(writeStrobeN));
   cover property ($fell(devDataOe));
endmodule // ahi_link_chk

// ### testbench/testbench.sv
// Bench joining both ends; Wishbone orders the host end.
`timescale 1ns/10ps
// ==========
// Bench top.
module testbench;
   import ahi_pkg::*;
   logic        ref_clk = 1'b0, reset = 1'b1, wbCyc = 1'b0, wbWe = 1'b0, wbAck;
   logic [4:0]  wbAdr = 5'h00;
   logic [7:0]  p;
   logic [2:0]  cs;
   logic [31:0] wbDat = 32'h0, wbRd, cfg, app, e, t, q[$];
   logic [95:0] r = 96'h0;
   int          num_errors = 0, total_checks = 0;
   ahi_link_if  link();
   ahi_device_end ahi_device_end_inst (.ref_clk, .reset, .link, .convResult(r),
      .converterConfig(cfg), .appliedConfig(app), .convStart(cs));
   ahi_host_end #(.HALF_CYCLES(4)) ahi_host_end_inst (.ref_clk, .reset, .wb_cyc_i(wbCyc),
      .wb_stb_i(wbCyc), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf),
      .wb_dat_i(wbDat), .wb_dat_o(wbRd), .wb_ack_o(wbAck), .link);
   ahi_link_chk ahi_link_chk_inst (.ref_clk, .reset, .interfaceSelect(link.interfaceSelect),
      .chipSelectN(link.chipSelectN), .writeStrobeN(link.writeStrobeN),
      .readStrobeN(link.readStrobeN), .frameSyncIn(link.frameSyncIn),
      .serialClock(link.serialClock), .hostDataOut(link.hostDataOut),
      .hostDataOe(link.hostDataOe), .devDataOe(link.devDataOe));
   initial forever #50 ref_clk = ~ref_clk;
   task automatic chk(string n, logic [31:0] x, logic [31:0] s);
      total_checks++;
      if (s !== x)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic wb(logic w, logic [4:0] a, logic [31:0] d);
      wbCyc <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbDat <= d;
      @(posedge ref_clk);
      while (wbAck !== 1'b1) @(posedge ref_clk);
      wbCyc <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(logic [4:0] a, logic [31:0] x);
      q.push_back(x);
      wb(1'b0, a, 32'h0);
   endtask
   task automatic op(logic [31:0] c, d, m);
      wb(1'b1, OFS_CTRL, c);
      wb(1'b1, OFS_TXDATA, d);
      wb(1'b1, OFS_CMD, m);
      do wb(1'b0, OFS_STATUS, 32'h0); while (wbRd[0] !== 1'b0);
      repeat (8) @(posedge ref_clk);
   endtask
   always @(posedge ref_clk)
      if (wbAck === 1'b1 && !wbWe && q.size() > 0)
         chk("read", q.pop_front(), wbRd);
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      #3_000_000;
      num_errors++;
      print_verdict();
   end
   initial
   begin
      void'($urandom(32'h4802));
      r <= {$urandom, $urandom, $urandom};
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk("config", CFG_RESET, cfg);
      op(32'hf1, $urandom | 32'h0001_0000, 32'h2001);
      chk("start", 32'h1, 32'(cs));
      rd(OFS_RXA, r[95:64]);
      rd(OFS_RXB, r[63:32]);
      rd(OFS_RXC, r[31:0]);
      chk("config", CFG_RESET, cfg);
      chk("applied", CFG_RESET & HW_OVERRIDE_MASK, app);
      e = ($urandom | 32'h0001_0000) & ~32'h0002_0000;
      op(32'h99, e, 32'h6001);
      rd(OFS_RXA, r[31:0]);
      chk("config", e, cfg);
      chk("applied", e, app);
      chk("start", e[SEQ_BIT] ? 32'h1 : 32'h7, 32'(cs));
      t = $urandom & ~32'h0001_0000;
      e = {t[31:24], e[23:0]};
      op(32'h39, t, 32'h3001);
      rd(OFS_RXA, {r[79:64], r[31:16]});
      rd(OFS_RXB, {r[47:32], r[15:0]});
      chk("config", e, cfg);
      e = $urandom | 32'h0003_0000;
      op(32'h19, e, 32'h2001);
      op(32'h19, 32'h0, 32'h2001);
      rd(OFS_RXA, e);
      e[31:24] = 8'h00;
      chk("config", e, cfg);
      t = $urandom;
      p = t[7:0];
      op(32'h408, t, 32'h2);
      e = {t[15:8], e[23:0]};
      chk("config", e, cfg);
      t = $urandom;
      op(32'h408, t, 32'h2);
      e = {e[31:24], p, t[15:0]};
      chk("config", e, cfg);
      e = $urandom;
      for (int i = 0; i < 4; i++)
         op(32'h40a, {16'h0, e[31 - 8 * i -: 8], 8'h00}, 32'h2);
      chk("config", e, cfg);
      op(32'h400, $urandom, 32'h2);
      chk("config", e, cfg);
      wb(1'b1, OFS_CTRL, 32'h0);
      repeat (8) @(posedge ref_clk);
      for (int i = 0; i < 6; i++)
      begin
         op(32'h400, 32'h0, 32'h3);
         rd(OFS_PRDATA, {16'h0, r[95 - 16 * i -: 16]});
      end
      for (int i = 0; i < 2; i++)
      begin
         op(32'h406, 32'h0, 32'h3);
         rd(OFS_PRDATA, {16'h0, r[95 - 8 * i -: 8], 8'h00});
      end
      print_verdict();
   end
endmodule // testbench
